// File: pkg/timer0_pkg.sv
// constants, register map and state layout of the timer0 block
// assumes a 20 MHz oscillator clock split into four phase clocks
package timer0_pkg;
    // clock and instruction cycle
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned PHASES_PER_INSTR = 4;
    localparam int unsigned INSTR_PERIOD_NS = CLK_PERIOD_NS * PHASES_PER_INSTR;
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_Q4 = 2'h3;
    localparam logic [1:0] WRITE_INHIBIT_INSTR = 2'h2;

    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_COUNT = 10'h001;
    localparam logic [9:0] IDX_INT_CTRL = 10'h00b;
    localparam logic [9:0] IDX_PRESCALE_CFG = 10'h081;
    localparam logic [9:0] IDX_PORT_A_DIR = 10'h085;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h090;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h091;
    localparam logic [9:0] IDX_SYS_CTRL = 10'h092;

    // reset values
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_INT_CTRL = 8'h00;
    localparam logic [7:0] RST_PRESCALE_CFG = 8'hff;
    localparam logic [5:0] RST_PORT_A_DIR = 6'h3f;

    // field positions
    localparam int unsigned CFG_CLOCK_SOURCE_SELECT = 5;
    localparam int unsigned CFG_COUNTER_EDGE_SELECT = 4;
    localparam int unsigned CFG_PRESCALER_ASSIGN = 3;
    localparam int unsigned INT_OVERFLOW_IRQ_ENABLE = 5;
    localparam int unsigned INT_OVERFLOW_FLAG = 2;
    localparam int unsigned IRQ_OVERFLOW = 0;
    localparam int unsigned IRQ_WATCHDOG_TICK = 1;
    localparam int unsigned SYS_SLEEP = 0;
    localparam int unsigned SYS_WATCHDOG_CLEAR = 1;

    typedef enum logic [1:0] {
        APB_WAIT = 2'b01,
        APB_ANSWER = 2'b10
    } apb_state_e;

    typedef struct packed {
        logic [1:0] phase;
        logic pin_s1;
        logic pin_s2;
        logic pin_s3;
        logic wd_s1;
        logic wd_s2;
        logic wd_s3;
        logic [7:0] count;
        logic [7:0] int_ctrl;
        logic [7:0] prescale_cfg;
        logic [5:0] port_a_dir;
        logic sleep;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic [7:0] prescale;
        logic [1:0] inhibit;
        logic samp_q2;
        logic samp_q4;
        apb_state_e apb_st;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic overflow_irq;
        logic watchdog_tick;
        logic watchdog_clear;
    } state_s;
endpackage

// File: design/timer0_with_shared_prescaler.sv
// timer0: 8-bit timer/counter with prescaler shared with the watchdog
// assumes an apb master on clk, and the watchdog counter outside
//
// Functional notes
// RULE1 - clock source clear and no prescaler: count once per instruction cycle
// RULE2 - a write to the count stops counting for two instruction cycles
// RULE3 - clock source set: count pin edges, edge select clear rising, set falling
// RULE4 - one prescaler serves timer when assign bit clear, watchdog when set
// RULE5 - timer assigned prescaler offers ratios 1:2 up to 1:256
// RULE6 - prescaler count is never readable nor loadable by software
// RULE7 - rollover from ff to 00 sets the overflow flag
// RULE8 - overflow interrupt requested only while its enable bit is set; the irq output ignores that bit and uses irq_mask
// RULE9 - software clears the overflow flag before re-enabling the interrupt
// RULE10 - sleep halts the timer, so no overflow happens in sleep
// RULE11 - prescaler output, not the pin, is sampled on Q2 and Q4; with the watchdog assigned the code samples pin_level directly
// RULE12 - external input divided by a counter with symmetrical output
// RULE13 - one 8-bit counter is timer prescaler or watchdog postscaler
// RULE14 - timer assigned: writing the count zeroes the prescaler only
// RULE15 - watchdog assigned: watchdog clear zeroes watchdog and prescaler
// RULE16 - software follows the fixed sequence to move prescaler to watchdog
// RULE17 - software clears watchdog then clears assign bit to move it back
// RULE18 - watchdog assigned: timer counts once per input event
// RULE19 - ratio value v divides timer by 2^(v+1), watchdog by 2^v
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module timer0_with_shared_prescaler (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic counter_input_pin,
    input wire logic watchdog_clock_pin,
    // watchdog side
    output logic watchdog_tick,
    output logic watchdog_clear,
    // interrupts
    output logic overflow_irq,
    output logic irq
);
    timer0_pkg::state_s s;
    timer0_pkg::state_s n;

    logic access;
    logic wr;
    logic [9:0] idx;
    logic mapped;
    logic [7:0] rdata;
    logic instr_tick;
    logic q2_tick;
    logic clock_source_select;
    logic counter_edge_select;
    logic prescaler_assign;
    logic [2:0] prescale_ratio_select;
    logic pin_level;
    logic pin_edge;
    logic wd_rise;
    logic ps_in;
    logic ps_src;
    logic sync_edge;
    logic inc_ev;
    logic ovf_ev;
    logic wd_out;
    logic wr_count;
    logic wd_clr_wr;
    logic [7:0] wd_mask;

    always_comb begin
        n = s;
        idx = paddr[11:2];
        access = psel && penable;
        wr = access && s.pready && pwrite;
        q2_tick = s.phase == timer0_pkg::PHASE_Q2;
        instr_tick = s.phase == timer0_pkg::PHASE_Q4;
        clock_source_select = s.prescale_cfg[timer0_pkg::CFG_CLOCK_SOURCE_SELECT];
        counter_edge_select = s.prescale_cfg[timer0_pkg::CFG_COUNTER_EDGE_SELECT];
        prescaler_assign = s.prescale_cfg[timer0_pkg::CFG_PRESCALER_ASSIGN];
        prescale_ratio_select = s.prescale_cfg[2:0];
        wr_count = wr && idx == timer0_pkg::IDX_COUNT;
        wd_clr_wr = wr && idx == timer0_pkg::IDX_SYS_CTRL
            && pwdata[timer0_pkg::SYS_WATCHDOG_CLEAR];

        // phase clocks and pin synchronisers
        n.phase = s.phase + 2'h1;
        n.pin_s1 = counter_input_pin;
        n.pin_s2 = s.pin_s1;
        n.pin_s3 = s.pin_s2;
        n.wd_s1 = watchdog_clock_pin;
        n.wd_s2 = s.wd_s1;
        n.wd_s3 = s.wd_s2;
        wd_rise = s.wd_s2 && !s.wd_s3;

        // falling edge select inverts the pin, so a rising edge always counts
        pin_level = s.pin_s2 ^ counter_edge_select; // [RULE3]
        pin_edge = pin_level && !(s.pin_s3 ^ counter_edge_select); // [RULE3]

        // shared prescaler input
        if (prescaler_assign) begin
            ps_in = wd_rise; // [RULE4] [RULE13]
        end else if (clock_source_select) begin
            ps_in = pin_edge && !s.sleep; // [RULE12]
        end else begin
            ps_in = instr_tick && !s.sleep;
        end

        // watchdog postscaler taps 2^v input ticks
        wd_mask = (8'h01 << prescale_ratio_select) - 8'h01; // [RULE19]
        wd_out = prescaler_assign ? (wd_rise && ((s.prescale & wd_mask) == wd_mask))
            : wd_rise;

        // timer source: bit v toggles every 2^v events, period 2^(v+1)
        if (!prescaler_assign) begin
            ps_src = s.prescale[prescale_ratio_select]; // [RULE5] [RULE12] [RULE19]
        end else begin
            ps_src = clock_source_select ? pin_level : 1'b0; // [RULE18]
        end

        // sample prescaler output on Q2 then Q4
        if (!s.sleep && q2_tick) begin
            n.samp_q2 = ps_src; // [RULE11]
        end
        if (!s.sleep && instr_tick) begin
            n.samp_q4 = s.samp_q2; // [RULE11]
        end
        sync_edge = instr_tick && s.samp_q2 && !s.samp_q4; // [RULE11]

        if (!clock_source_select && prescaler_assign) begin
            inc_ev = instr_tick; // [RULE1] [RULE18]
        end else begin
            inc_ev = sync_edge;
        end
        inc_ev = inc_ev && !s.sleep && s.inhibit == 2'h0; // [RULE2] [RULE10]
        ovf_ev = inc_ev && s.count == 8'hff && !wr_count; // [RULE7]

        // prescaler counter, cleared by count write when timer assigned, by watchdog clear when watchdog assigned
        if (ps_in) begin
            n.prescale = s.prescale + 8'h01; // [RULE13]
        end
        if (wr_count && !prescaler_assign) begin
            n.prescale = 8'h00; // [RULE14]
        end
        if (wd_clr_wr && prescaler_assign) begin
            n.prescale = 8'h00; // [RULE15]
        end

        // count and write inhibit
        if (instr_tick && s.inhibit != 2'h0) begin
            n.inhibit = s.inhibit - 2'h1;
        end
        if (inc_ev) begin
            n.count = s.count + 8'h01; // [RULE1] [RULE3]
        end
        if (wr_count) begin
            n.count = pwdata[7:0];
            n.inhibit = timer0_pkg::WRITE_INHIBIT_INSTR; // [RULE2]
        end

        // register writes
        if (wr) begin
            case (idx)
                timer0_pkg::IDX_INT_CTRL: begin
                    n.int_ctrl = pwdata[7:0];
                end
                timer0_pkg::IDX_PRESCALE_CFG: begin
                    n.prescale_cfg = pwdata[7:0];
                end
                timer0_pkg::IDX_PORT_A_DIR: begin
                    n.port_a_dir = pwdata[5:0];
                end
                timer0_pkg::IDX_IRQ_STATUS: begin
                    n.irq_status = s.irq_status & ~pwdata[1:0];
                end
                timer0_pkg::IDX_IRQ_MASK: begin
                    n.irq_mask = pwdata[1:0];
                end
                timer0_pkg::IDX_SYS_CTRL: begin
                    n.sleep = pwdata[timer0_pkg::SYS_SLEEP];
                end
                default: begin
                end
            endcase
        end
        // hardware sets win over software clears
        if (ovf_ev) begin
            n.int_ctrl[timer0_pkg::INT_OVERFLOW_FLAG] = 1'b1; // [RULE7] [RULE9]
            n.irq_status[timer0_pkg::IRQ_OVERFLOW] = 1'b1;
        end
        if (wd_out) begin
            n.irq_status[timer0_pkg::IRQ_WATCHDOG_TICK] = 1'b1;
        end

        // outputs
        n.watchdog_tick = wd_out;
        n.watchdog_clear = wd_clr_wr;
        n.overflow_irq = n.int_ctrl[timer0_pkg::INT_OVERFLOW_FLAG]
            && n.int_ctrl[timer0_pkg::INT_OVERFLOW_IRQ_ENABLE]; // [RULE8]
        n.irq = |(n.irq_status & n.irq_mask);

        // apb read decode; the prescaler has no address
        mapped = 1'b1;
        case (idx)
            timer0_pkg::IDX_COUNT: rdata = s.count;
            timer0_pkg::IDX_INT_CTRL: rdata = s.int_ctrl;
            timer0_pkg::IDX_PRESCALE_CFG: rdata = s.prescale_cfg;
            timer0_pkg::IDX_PORT_A_DIR: rdata = {2'h0, s.port_a_dir};
            timer0_pkg::IDX_IRQ_STATUS: rdata = {6'h00, s.irq_status};
            timer0_pkg::IDX_IRQ_MASK: rdata = {6'h00, s.irq_mask};
            timer0_pkg::IDX_SYS_CTRL: rdata = {7'h00, s.sleep};
            default: begin
                rdata = 8'h00; // [RULE6]
                mapped = 1'b0;
            end
        endcase

        // one wait state: answer registered on the first access edge
        case (s.apb_st)
            timer0_pkg::APB_WAIT: begin
                if (access) begin
                    n.apb_st = timer0_pkg::APB_ANSWER;
                    n.pready = 1'b1;
                    n.pslverr = !mapped;
                    n.prdata = pwrite ? 32'h0000_0000 : {24'h000000, rdata};
                end
            end
            timer0_pkg::APB_ANSWER: begin
                n.apb_st = timer0_pkg::APB_WAIT;
                n.pready = 1'b0;
                n.pslverr = 1'b0;
                n.prdata = 32'h0000_0000;
            end
            default: begin
                n.apb_st = timer0_pkg::APB_WAIT;
                n.pready = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.count <= timer0_pkg::RST_COUNT;
            s.int_ctrl <= timer0_pkg::RST_INT_CTRL;
            s.prescale_cfg <= timer0_pkg::RST_PRESCALE_CFG;
            s.port_a_dir <= timer0_pkg::RST_PORT_A_DIR;
            s.apb_st <= timer0_pkg::APB_WAIT;
            // samplers start high, as an idle low pin reads after the reset falling edge select, so no false edge
            s.samp_q2 <= timer0_pkg::RST_PRESCALE_CFG[timer0_pkg::CFG_COUNTER_EDGE_SELECT];
            s.samp_q4 <= timer0_pkg::RST_PRESCALE_CFG[timer0_pkg::CFG_COUNTER_EDGE_SELECT];
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign watchdog_tick = s.watchdog_tick;
    assign watchdog_clear = s.watchdog_clear;
    assign overflow_irq = s.overflow_irq;
    assign irq = s.irq;

    // checks
    a_instr_tick_count: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
        (instr_tick && !clock_source_select && prescaler_assign && !s.sleep
            && s.inhibit == 2'h0 && !wr_count)
        |=> s.count == $past(s.count) + 8'h01)
        else $error("count missed an instruction cycle");

    a_write_inhibit_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
        wr_count |=> s.count == $past(pwdata[7:0])
            && s.inhibit == timer0_pkg::WRITE_INHIBIT_INSTR)
        else $error("count write not loaded with inhibit");

    a_inhibit_freezes_count: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
        s.inhibit != 2'h0 && !wr_count |=> $stable(s.count))
        else $error("count moved inside write inhibit");

    a_overflow_sets_flag: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
        ovf_ev |=> s.count == 8'h00 && s.int_ctrl[timer0_pkg::INT_OVERFLOW_FLAG]
            && s.irq_status[timer0_pkg::IRQ_OVERFLOW])
        else $error("rollover did not set overflow flag");

    a_irq_needs_enable: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
        !s.int_ctrl[timer0_pkg::INT_OVERFLOW_IRQ_ENABLE] && !wr |=> !s.overflow_irq)
        else $error("overflow interrupt without enable");

    a_sleep_halts_count: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
        s.sleep && !wr_count |=> $stable(s.count))
        else $error("count moved during sleep");

    a_count_on_q4: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
        (s.count != $past(s.count)) && !$past(wr_count)
        |-> $past(s.phase) == timer0_pkg::PHASE_Q4)
        else $error("count advanced off the Q4 phase");

    a_write_clears_pscale: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
        wr_count && !prescaler_assign |=> s.prescale == 8'h00 && $stable(s.prescale_cfg))
        else $error("count write did not clear prescaler");

    a_wd_clear_pscale: assert property (@(posedge clk) disable iff (!rst_n) // [RULE15]
        wd_clr_wr && prescaler_assign |=> s.prescale == 8'h00 && s.watchdog_clear)
        else $error("watchdog clear did not clear prescaler");

    a_wd_ratio_one: assert property (@(posedge clk) disable iff (!rst_n) // [RULE19]
        prescaler_assign && prescale_ratio_select == 3'h0 && wd_rise |=> s.watchdog_tick)
        else $error("watchdog 1:1 tick missing");
endmodule

// File: testbench/ext_clock_source.sv
// external clock source for a pin of the timer0 block
// assumes the bench calls toggle from its own sequence on clk
`timescale 1ns/1ps
module ext_clock_source (
    // reference clock
    input wire logic clk,
    // driven pin
    output logic pin
);
    initial begin
        pin = 1'b0;
    end

    // level held sp clk periods, at least two clk high and low
    task automatic toggle(input int n, input int sp);
        repeat (n) begin
            repeat (sp) @(posedge clk);
            pin <= ~pin;
        end
    endtask
endmodule

// File: testbench/tb_timer0_with_shared_prescaler.sv
// self-checking bench for the timer0 block
// assumes apb with one wait state and the pin sources in ext_clock_source
`timescale 1ns/1ps
module tb_timer0_with_shared_prescaler;
    logic clk, rst_n, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic pready, pslverr, counter_input_pin, watchdog_clock_pin;
    logic watchdog_tick, watchdog_clear, overflow_irq, irq;
    logic [7:0] a;
    int errors, check_count, ticks, clears, model_count;
    logic [9:0] ridx [5] = '{timer0_pkg::IDX_PRESCALE_CFG, timer0_pkg::IDX_PORT_A_DIR,
        timer0_pkg::IDX_COUNT, timer0_pkg::IDX_INT_CTRL, 10'h002};
    logic [7:0] rexp [5] = '{8'hff, 8'h3f, 8'h00, 8'h00, 8'h00};
    logic [9:0] iidx [6] = '{timer0_pkg::IDX_INT_CTRL, timer0_pkg::IDX_INT_CTRL,
        timer0_pkg::IDX_IRQ_MASK, timer0_pkg::IDX_IRQ_MASK, timer0_pkg::IDX_IRQ_MASK,
        timer0_pkg::IDX_IRQ_STATUS};
    logic [7:0] ival [6] = '{8'h24, 8'h20, 8'h01, 8'h00, 8'h01, 8'h01};
    logic [1:0] iexp [6] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0};
    logic [7:0] ccfg [3] = '{8'h28, 8'h38, 8'h20};
    int ctog [3] = '{7, 7, 16};

    timer0_with_shared_prescaler timer0_with_shared_prescaler_inst (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .counter_input_pin(counter_input_pin),
        .watchdog_clock_pin(watchdog_clock_pin), .watchdog_tick(watchdog_tick),
        .watchdog_clear(watchdog_clear), .overflow_irq(overflow_irq), .irq(irq));
    ext_clock_source cnt_src (.clk(clk), .pin(counter_input_pin));
    ext_clock_source wd_src (.clk(clk), .pin(watchdog_clock_pin));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        if (watchdog_tick === 1'b1) ticks++;
        if (watchdog_clear === 1'b1) clears++;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic [9:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] v);
        apb(idx, 1'b1, {24'h0, v});
    endtask

    task automatic rchk(input string nm, input logic [9:0] idx, input logic [31:0] exp);
        apb(idx, 1'b0, 32'h0);
        check(nm, rd, exp);
    endtask

    initial begin
        #(60000 * 50);
        errors++;
        test_done();
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        seed = 32'd34;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rchk("reset", ridx[i], {24'h0, rexp[i]});
        end
        check("slverr", {31'h0, err}, 32'h1);
        $display("reset test done");
        wr(timer0_pkg::IDX_PRESCALE_CFG, 8'h08);
        wr(timer0_pkg::IDX_COUNT, 8'hfe);
        repeat (38) @(posedge clk);
        model_count = (8'hfe + 10 - 2) % 256;
        rchk("inhibit", timer0_pkg::IDX_COUNT, model_count);
        a = rd[7:0];
        repeat (36) @(posedge clk);
        apb(timer0_pkg::IDX_COUNT, 1'b0, 32'h0);
        check("rate", {24'h0, rd[7:0] - a}, 32'd10);
        rchk("flag", timer0_pkg::IDX_INT_CTRL, 32'h04);
        check("irq_off", {31'h0, overflow_irq}, 32'h0);
        rchk("status", timer0_pkg::IDX_IRQ_STATUS, 32'h1);
        $display("timer test done");
        wr(timer0_pkg::IDX_SYS_CTRL, 8'h01);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(timer0_pkg::IDX_COUNT, seed[7:0]);
            repeat (20) @(posedge clk);
            rchk("sleep", timer0_pkg::IDX_COUNT, {24'h0, seed[7:0]});
            wr(timer0_pkg::IDX_PORT_A_DIR, seed[15:8]);
            rchk("dir", timer0_pkg::IDX_PORT_A_DIR, {26'h0, seed[13:8]});
        end
        for (int i = 0; i < 6; i++) begin
            wr(iidx[i], ival[i]);
            repeat (2) @(posedge clk);
            check("irq", {30'h0, overflow_irq, irq}, {30'h0, iexp[i]});
        end
        rchk("w1c", timer0_pkg::IDX_IRQ_STATUS, 32'h0);
        wr(timer0_pkg::IDX_SYS_CTRL, 8'h00);
        $display("irq test done");
        for (int v = 0; v < 8; v++) begin
            wr(timer0_pkg::IDX_PRESCALE_CFG, 8'(v));
            wr(timer0_pkg::IDX_COUNT, 8'h00);
            repeat (12) @(posedge clk);
            apb(timer0_pkg::IDX_COUNT, 1'b0, 32'h0);
            a = rd[7:0];
            repeat ((32 << v) - 4) @(posedge clk);
            apb(timer0_pkg::IDX_COUNT, 1'b0, 32'h0);
            check("ratio", {24'h0, rd[7:0] - a}, 32'd4);
        end
        $display("ratio test done");
        for (int i = 0; i < 3; i++) begin
            wr(timer0_pkg::IDX_PRESCALE_CFG, ccfg[i]);
            wr(timer0_pkg::IDX_COUNT, 8'h00);
            repeat (12) @(posedge clk);
            cnt_src.toggle(ctog[i], 8);
            repeat (20) @(posedge clk);
            rchk("counter", timer0_pkg::IDX_COUNT, 32'd4);
        end
        $display("counter test done");
        wr(timer0_pkg::IDX_COUNT, 8'h00);
        wr(timer0_pkg::IDX_PRESCALE_CFG, 8'h28);
        wr(timer0_pkg::IDX_SYS_CTRL, 8'h02);
        ticks = 0;
        wd_src.toggle(4, 8);
        repeat (20) @(posedge clk);
        check("ticks_one", ticks, 32'd2);
        wr(timer0_pkg::IDX_PRESCALE_CFG, 8'h2a);
        ticks = 0;
        wd_src.toggle(16, 8);
        repeat (20) @(posedge clk);
        check("ticks", ticks, 32'd2);
        wr(timer0_pkg::IDX_SYS_CTRL, 8'h02);
        wr(timer0_pkg::IDX_PRESCALE_CFG, 8'h00);
        repeat (4) @(posedge clk);
        check("clears", clears, 32'd2);
        $display("watchdog test done");
        test_done();
    end
endmodule
